// ---- hdl/lbc_dev.sv ----
// LED driver end: serial slave, registers and brightness PWM
//
// Contract
// - Reset pin low restores registers, disables outputs
// - Controller keeps reset pin high normally
// - Data changes only while clock low
// - Data falling with clock high starts session
// - Data rising with clock high stops session
// - Only master makes start and stop
// - Bus busy from start until stop
// - Repeated start restarts address reception
// - Eight bits MSB first, then ack slot
// - Master releases, device pulls low ninth pulse
// - Device acknowledges address, register, data bytes
// - Seven-bit address plus direction, own address only
// - Register byte then data byte stored
// - Registers at 10h, A0h and C0h
// - Power-on values 20h, E0h, FCh
// - Enable bits for main, aux, fifth sense
// - Master writes zero to test bits
// - Main code five low bits, all ones full
// - Aux code two low bits, 11 full
// - Codes 00-18 map current and duty
// - Codes 19-1F map 70 or 100 percent
// - Aux codes give 20/40/70/100 percent analog
// - Main PWM 20 kHz, sixteen steps
`timescale 1ns/1ns
module lbc_dev (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    lbc_if.dev link,
    output logic main_sink_on_o,
    output lbc_pkg::lbc_level_t main_level_o,
    output logic aux_sink_on_o,
    output lbc_pkg::lbc_level_t aux_level_o,
    output logic fifth_sense_en_o,
    output logic bus_busy_o
);

    ////////////////////////////////////////////////////////////////////////
    // Main code decode to analog step and duty
    function automatic lbc_pkg::lbc_main_map_t lbc_main_map(input logic [4:0] code);
        lbc_pkg::lbc_main_map_t m;
        m.lvl = lbc_pkg::LBC_LVL_100;
        m.duty = lbc_pkg::DUTY_FULL;
        if (code < lbc_pkg::CODE_40_FIRST)
        begin
            m.lvl = lbc_pkg::LBC_LVL_20;
            m.duty = code + lbc_pkg::DUTY_20_BASE;
        end
        else if (code < lbc_pkg::CODE_70_FIRST)
        begin
            m.lvl = lbc_pkg::LBC_LVL_40;
            m.duty = code - lbc_pkg::CODE_40_FIRST + lbc_pkg::DUTY_40_BASE;
        end
        else if (code < lbc_pkg::CODE_100_FIRST)
        begin
            m.lvl = lbc_pkg::LBC_LVL_70;
            m.duty = code - lbc_pkg::CODE_70_FIRST + lbc_pkg::DUTY_70_BASE;
        end
        else if (code == lbc_pkg::CODE_100_FIRST)
        begin
            m.duty = lbc_pkg::DUTY_100_LOW;
        end
        else if (code == lbc_pkg::CODE_100_MID)
        begin
            m.duty = lbc_pkg::DUTY_100_MID;
        end
        return m;
    endfunction : lbc_main_map

    ////////////////////////////////////////////////////////////////////////
    // Link-clock state: shifter, byte framing, ack request, write capture
    typedef struct packed {
        logic [3:0] bit_cnt;
        logic [1:0] byte_idx;
        logic [7:0] shift;
        logic addr_ok;
        logic [7:0] reg_sel;
        logic [7:0] data;
        logic ack_req;
        logic wr_pend;
    } lbc_link_t;

    localparam lbc_link_t LINK_RESET = '0;

    // Core-clock state: pin synchronisers, bus state, registers, PWM
    typedef struct packed {
        logic scl_s1;
        logic scl_s2;
        logic scl_p;
        logic sda_s1;
        logic sda_s2;
        logic sda_p;
        logic ext_s1;
        logic ext_s2;
        logic ack_s1;
        logic ack_s2;
        logic wr_s1;
        logic wr_s2;
        logic wr_p;
        logic busy;
        logic link_rstn;
        logic drive;
        logic [7:0] gen;
        logic [7:0] main;
        logic [7:0] aux;
        logic [7:0] pwm_div;
        logic [3:0] phase;
        logic main_on;
        logic aux_on;
        logic sense_en;
        lbc_pkg::lbc_level_t main_lvl;
        lbc_pkg::lbc_level_t aux_lvl;
    } lbc_core_t;

    localparam lbc_core_t CORE_RESET = '{
        gen: lbc_pkg::RST_GENERAL_ENABLE,
        main: lbc_pkg::RST_MAIN_BANK_BRIGHTNESS,
        aux: lbc_pkg::RST_AUX_SINK_BRIGHTNESS,
        main_lvl: lbc_pkg::LBC_LVL_20,
        aux_lvl: lbc_pkg::LBC_LVL_20,
        default: '0
    };

    lbc_link_t l_q;
    lbc_link_t l_d;
    lbc_core_t c_q;
    lbc_core_t c_d;
    logic [7:0] rx_byte;
    lbc_pkg::lbc_main_map_t main_map;

    ////////////////////////////////////////////////////////////////////////
    // Link side: sample data on each data-bit clock rise, frame bytes
    assign rx_byte = {l_q.shift[6:0], link.sda};

    always_comb
    begin
        l_d = l_q;
        if (l_q.bit_cnt == lbc_pkg::ACK_SLOT)
        begin
            l_d.bit_cnt = '0;
            l_d.ack_req = 1'h0;
            if (l_q.byte_idx != lbc_pkg::BYTE_EXTRA)
            begin
                l_d.byte_idx = l_q.byte_idx + 2'h1;
            end
        end
        else
        begin
            l_d.shift = rx_byte;
            l_d.bit_cnt = l_q.bit_cnt + 4'h1;
            if (l_q.bit_cnt == lbc_pkg::LAST_DATA_BIT)
            begin
                unique case (l_q.byte_idx)
                    lbc_pkg::BYTE_ADDR:
                    begin
                        l_d.addr_ok = (rx_byte[7:1] == lbc_pkg::DEV_ADDR)
                                      && (rx_byte[0] == lbc_pkg::RW_WRITE);
                        l_d.ack_req = l_d.addr_ok;
                    end
                    lbc_pkg::BYTE_REG:
                    begin
                        l_d.reg_sel = rx_byte;
                        l_d.ack_req = l_q.addr_ok;
                    end
                    lbc_pkg::BYTE_DATA:
                    begin
                        l_d.data = rx_byte;
                        l_d.wr_pend = l_q.addr_ok;
                        l_d.ack_req = l_q.addr_ok;
                    end
                    lbc_pkg::BYTE_EXTRA:
                    begin
                        l_d.ack_req = l_q.addr_ok;
                    end
                endcase
            end
        end
    end

    // Held in reset while the bus is free and on every start
    always_ff @(posedge link.scl or negedge c_q.link_rstn)
    begin
        if (!c_q.link_rstn)
        begin
            l_q <= LINK_RESET;
        end
        else
        begin
            l_q <= l_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core side: conditions, ack pin, register writes, PWM
    assign main_map = lbc_main_map(c_q.main[4:0]);

    always_comb
    begin
        logic scl_high;
        logic start;
        logic stop;
        logic wr_rise;
        scl_high = 1'h0;
        start = 1'h0;
        stop = 1'h0;
        wr_rise = 1'h0;
        c_d = c_q;
        // Two-stage synchronisers and their previous samples
        c_d.scl_s1 = link.scl;
        c_d.scl_s2 = c_q.scl_s1;
        c_d.scl_p = c_q.scl_s2;
        c_d.sda_s1 = link.sda;
        c_d.sda_s2 = c_q.sda_s1;
        c_d.sda_p = c_q.sda_s2;
        c_d.ext_s1 = link.ext_resetn;
        c_d.ext_s2 = c_q.ext_s1;
        c_d.ack_s1 = l_q.ack_req;
        c_d.ack_s2 = c_q.ack_s1;
        c_d.wr_s1 = l_q.wr_pend;
        c_d.wr_s2 = c_q.wr_s1;
        c_d.wr_p = c_q.wr_s2;
        scl_high = c_q.scl_s2 & c_q.scl_p;
        start = scl_high & c_q.sda_p & ~c_q.sda_s2;
        stop = scl_high & ~c_q.sda_p & c_q.sda_s2;
        wr_rise = c_q.wr_s2 & ~c_q.wr_p;
        // Bus state and link reset
        if (start)
        begin
            c_d.busy = 1'h1;
            c_d.drive = 1'h0;
        end
        else if (stop)
        begin
            c_d.busy = 1'h0;
            c_d.drive = 1'h0;
        end
        else if (c_q.scl_p & ~c_q.scl_s2 & c_q.busy)
        begin
            c_d.drive = c_q.ack_s2;
        end
        c_d.link_rstn = c_d.busy & ~start;
        // Register write, unknown offsets dropped
        if (wr_rise)
        begin
            unique case (l_q.reg_sel)
                lbc_pkg::REG_GENERAL_ENABLE: c_d.gen = l_q.data;
                lbc_pkg::REG_MAIN_BANK_BRIGHTNESS: c_d.main = l_q.data;
                lbc_pkg::REG_AUX_SINK_BRIGHTNESS: c_d.aux = l_q.data;
                default: c_d.gen = c_q.gen;
            endcase
        end
        // PWM step timer and sixteen-step phase
        if (c_q.pwm_div == lbc_pkg::PWM_STEP_LAST)
        begin
            c_d.pwm_div = '0;
            c_d.phase = c_q.phase + 4'h1;
        end
        else
        begin
            c_d.pwm_div = c_q.pwm_div + 8'h01;
        end
        // Sink controls
        c_d.main_on = c_q.gen[lbc_pkg::GEN_MAIN_EN_BIT]
                      & ({1'h0, c_q.phase} < main_map.duty);
        c_d.main_lvl = main_map.lvl;
        c_d.aux_on = c_q.gen[lbc_pkg::GEN_AUX_EN_BIT];
        c_d.aux_lvl = lbc_pkg::lbc_level_t'(c_q.aux[1:0]);
        c_d.sense_en = c_q.gen[lbc_pkg::GEN_FIFTH_SENSE_BIT];
        // Reset pin: everything but the pin synchronisers returns to power-on
        if (!c_q.ext_s2)
        begin
            c_d = CORE_RESET;
            c_d.scl_s1 = link.scl;
            c_d.scl_s2 = c_q.scl_s1;
            c_d.scl_p = c_q.scl_s2;
            c_d.sda_s1 = link.sda;
            c_d.sda_s2 = c_q.sda_s1;
            c_d.sda_p = c_q.sda_s2;
            c_d.ext_s1 = link.ext_resetn;
            c_d.ext_s2 = c_q.ext_s1;
        end
    end

    // Core register, synchronous active-low reset
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            c_q <= CORE_RESET;
        end
        else
        begin
            c_q <= c_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    assign link.sda_s_o = 1'h0;
    assign link.sda_s_oe_n = ~c_q.drive;
    assign main_sink_on_o = c_q.main_on;
    assign main_level_o = c_q.main_lvl;
    assign aux_sink_on_o = c_q.aux_on;
    assign aux_level_o = c_q.aux_lvl;
    assign fifth_sense_en_o = c_q.sense_en;
    assign bus_busy_o = c_q.busy;

endmodule : lbc_dev

// ---- include/lbc_pkg.sv ----
// Shared constants and types for the LED brightness two-wire link
package lbc_pkg;

    // Clocking and bus timing
    localparam int CLK_HZ = 50_000_000;
    localparam int CLK_NS = 20;
    localparam int SCL_PERIOD_NS = 2500;
    localparam int SCL_QTR_CYC_I = (SCL_PERIOD_NS / 4 + CLK_NS - 1) / CLK_NS;
    localparam logic [5:0] SCL_QTR_LAST = 6'(SCL_QTR_CYC_I - 1);

    // Slave address of the driver (value is arbitrary) and direction
    localparam logic [6:0] DEV_ADDR = 7'h2a;
    localparam logic RW_WRITE = 1'h0;

    // Byte framing
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    localparam logic [1:0] BYTE_ADDR = 2'h0;
    localparam logic [1:0] BYTE_REG = 2'h1;
    localparam logic [1:0] BYTE_DATA = 2'h2;
    localparam logic [1:0] BYTE_EXTRA = 2'h3;

    // Register offsets and power-on values
    localparam logic [7:0] REG_GENERAL_ENABLE = 8'h10;
    localparam logic [7:0] REG_MAIN_BANK_BRIGHTNESS = 8'ha0;
    localparam logic [7:0] REG_AUX_SINK_BRIGHTNESS = 8'hc0;
    localparam logic [7:0] RST_GENERAL_ENABLE = 8'h20;
    localparam logic [7:0] RST_MAIN_BANK_BRIGHTNESS = 8'he0;
    localparam logic [7:0] RST_AUX_SINK_BRIGHTNESS = 8'hfc;

    // General enable field positions
    localparam int GEN_MAIN_EN_BIT = 0;
    localparam int GEN_TEST_BIT_LOW = 1;
    localparam int GEN_AUX_EN_BIT = 2;
    localparam int GEN_FIFTH_SENSE_BIT = 5;
    localparam int GEN_TEST_BIT_HIGH = 6;

    // Analog current steps
    typedef enum logic [1:0] {
        LBC_LVL_20 = 2'h0,
        LBC_LVL_40 = 2'h1,
        LBC_LVL_70 = 2'h2,
        LBC_LVL_100 = 2'h3
    } lbc_level_t;

    typedef struct packed {
        lbc_level_t lvl;
        logic [4:0] duty;
    } lbc_main_map_t;

    // Main code boundaries and duty figures in sixteenths
    localparam logic [4:0] CODE_40_FIRST = 5'h10;
    localparam logic [4:0] CODE_70_FIRST = 5'h17;
    localparam logic [4:0] CODE_100_FIRST = 5'h1d;
    localparam logic [4:0] CODE_100_MID = 5'h1e;
    localparam logic [4:0] DUTY_20_BASE = 5'h01;
    localparam logic [4:0] DUTY_40_BASE = 5'h0a;
    localparam logic [4:0] DUTY_70_BASE = 5'h0b;
    localparam logic [4:0] DUTY_100_LOW = 5'h0d;
    localparam logic [4:0] DUTY_100_MID = 5'h0f;
    localparam logic [4:0] DUTY_FULL = 5'h10;

    // PWM: fixed frame rate, sixteen duty steps
    localparam int PWM_FREQ_HZ = 20_000;
    localparam int PWM_STEPS = 16;
    localparam logic [7:0] PWM_STEP_LAST = 8'(CLK_HZ / (PWM_FREQ_HZ * PWM_STEPS) - 1);

endpackage : lbc_pkg

// ---- include/lbc_if.sv ----
// Two-wire link between bus master and LED driver, with open-drain data
`timescale 1ns/1ns
interface lbc_if;
    logic scl;
    logic sda_m_o;
    logic sda_m_oe_n;
    logic sda_s_o;
    logic sda_s_oe_n;
    logic ext_resetn;
    logic sda;

    // Wired-and data line with pull-up
    assign sda = (sda_m_oe_n | sda_m_o) & (sda_s_oe_n | sda_s_o);

    modport host (
        output scl,
        output sda_m_o,
        output sda_m_oe_n,
        output ext_resetn,
        input sda
    );

    modport dev (
        input scl,
        input sda,
        input ext_resetn,
        output sda_s_o,
        output sda_s_oe_n
    );
endinterface : lbc_if

// ---- hdl/lbc_host.sv ----
// Bus master end: divides the core clock into the link clock, writes one register
`timescale 1ns/1ns
module lbc_host (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    lbc_if.host link,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_reg_i,
    input wire logic [7:0] cmd_data_i,
    input wire logic dev_reset_req_i,
    output logic cmd_ready_o,
    output logic done_o,
    output logic nack_o
);

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef enum logic [1:0] {
        LBC_H_IDLE = 2'b00,
        LBC_H_START = 2'b01,
        LBC_H_BITS = 2'b10,
        LBC_H_STOP = 2'b11
    } lbc_hstate_t;

    typedef struct packed {
        lbc_hstate_t st;
        logic [5:0] tick;
        logic [1:0] qtr;
        logic [3:0] bit_cnt;
        logic [1:0] byte_cnt;
        logic [7:0] shift;
        logic [7:0] data;
        logic scl;
        logic oe_n;
        logic ext_rstn;
        logic sda_s1;
        logic sda_s2;
        logic nack;
        logic done;
        logic ready;
    } lbc_host_t;

    localparam lbc_host_t HOST_RESET = '{
        st: LBC_H_IDLE,
        scl: 1'h1,
        oe_n: 1'h1,
        ext_rstn: 1'h1,
        ready: 1'h1,
        default: '0
    };

    lbc_host_t h_q;
    lbc_host_t h_d;

    ////////////////////////////////////////////////////////////////////////
    // Quarter-period sequencer for start, bits, acks and stop
    always_comb
    begin
        logic qend;
        qend = (h_q.tick == lbc_pkg::SCL_QTR_LAST);
        h_d = h_q;
        h_d.sda_s1 = link.sda;
        h_d.sda_s2 = h_q.sda_s1;
        h_d.ext_rstn = ~dev_reset_req_i;
        h_d.done = 1'h0;
        h_d.tick = qend ? '0 : h_q.tick + 6'h01;
        if (qend)
        begin
            h_d.qtr = h_q.qtr + 2'h1;
        end
        unique case (h_q.st)
            LBC_H_IDLE:
            begin
                h_d.tick = '0;
                h_d.qtr = '0;
                if (cmd_valid_i)
                begin
                    h_d.st = LBC_H_START;
                    h_d.ready = 1'h0;
                    h_d.nack = 1'h0;
                    h_d.shift = {lbc_pkg::DEV_ADDR, lbc_pkg::RW_WRITE};
                    h_d.data = cmd_data_i;
                    h_d.byte_cnt = lbc_pkg::BYTE_ADDR;
                    h_d.bit_cnt = '0;
                    h_d.scl = 1'h1;
                    h_d.oe_n = 1'h1;
                end
            end
            LBC_H_START:
            begin
                if (qend && h_q.qtr == 2'h1)
                begin
                    h_d.oe_n = 1'h0;
                end
                if (qend && h_q.qtr == 2'h3)
                begin
                    h_d.scl = 1'h0;
                    h_d.st = LBC_H_BITS;
                end
            end
            LBC_H_BITS:
            begin
                if (qend)
                begin
                    unique case (h_q.qtr)
                        2'h0: h_d.oe_n = (h_q.bit_cnt == lbc_pkg::ACK_SLOT) | h_q.shift[7];
                        2'h1: h_d.scl = 1'h1;
                        2'h2: h_d.nack = h_q.nack | ((h_q.bit_cnt == lbc_pkg::ACK_SLOT) & h_q.sda_s2);
                        2'h3: h_d.scl = 1'h0;
                    endcase
                end
                if (qend && h_q.qtr == 2'h3)
                begin
                    if (h_q.bit_cnt != lbc_pkg::ACK_SLOT)
                    begin
                        h_d.bit_cnt = h_q.bit_cnt + 4'h1;
                        h_d.shift = {h_q.shift[6:0], 1'h0};
                    end
                    else if (h_q.byte_cnt == lbc_pkg::BYTE_DATA)
                    begin
                        h_d.st = LBC_H_STOP;
                    end
                    else
                    begin
                        h_d.bit_cnt = '0;
                        h_d.byte_cnt = h_q.byte_cnt + 2'h1;
                        h_d.shift = (h_q.byte_cnt == lbc_pkg::BYTE_ADDR) ? cmd_reg_i : h_q.data;
                    end
                end
            end
            LBC_H_STOP:
            begin
                if (qend)
                begin
                    unique case (h_q.qtr)
                        2'h0: h_d.oe_n = 1'h0;
                        2'h1: h_d.scl = 1'h1;
                        2'h2: h_d.oe_n = 1'h1;
                        2'h3:
                        begin
                            h_d.st = LBC_H_IDLE;
                            h_d.done = 1'h1;
                            h_d.ready = 1'h1;
                        end
                    endcase
                end
            end
        endcase
    end

    // State register, synchronous active-low reset
    always_ff @(posedge clk_sys_i)
    begin
        if (!resetn_i)
        begin
            h_q <= HOST_RESET;
        end
        else
        begin
            h_q <= h_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    assign link.scl = h_q.scl;
    assign link.sda_m_o = 1'h0;
    assign link.sda_m_oe_n = h_q.oe_n;
    assign link.ext_resetn = h_q.ext_rstn;
    assign cmd_ready_o = h_q.ready;
    assign done_o = h_q.done;
    assign nack_o = h_q.nack;

endmodule : lbc_host

// ---- testbench/lbc_link_props.sv ----
// Protocol checker watching the two-wire link between master and LED driver
`timescale 1ns/1ns
module lbc_link_props (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic scl,
    input wire logic sda_m_o,
    input wire logic sda_m_oe_n,
    input wire logic sda_s_o,
    input wire logic sda_s_oe_n,
    input wire logic ext_resetn,
    input wire logic sda
);
    logic [3:0] bit_q;
    logic [1:0] byte_q;
    logic scl_q;
    logic sda_q;
    logic [7:0] addr_w;

    assign addr_w = {lbc_pkg::DEV_ADDR, lbc_pkg::RW_WRITE};

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    ////////////////////////////////////////////////////////////////
    // Bit and byte position within a frame, restarted by every start
    always_ff @(posedge clk_sys_i)
    begin
        scl_q <= scl;
        sda_q <= sda;
        if (!resetn_i || (scl && scl_q && sda_q && !sda))
        begin
            bit_q <= 4'h0;
            byte_q <= 2'h0;
        end
        else if (scl && !scl_q)
        begin
            bit_q <= (bit_q == 4'h8) ? 4'h0 : bit_q + 4'h1;
            byte_q <= (bit_q == 4'h8) ? byte_q + 2'h1 : byte_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Framing events on the wire
    sequence s_start;
        scl && $past(scl) && $fell(sda);
    endsequence
    sequence s_stop;
        scl && $past(scl) && $rose(sda);
    endsequence
    sequence s_ack_edge;
        $rose(scl) && bit_q == 4'h8;
    endsequence

    chk_start_clock_high: assert property (s_start |-> scl[*8])
        else $error("start not followed by clock high");
    chk_stop_bus_idle: assert property (s_stop |-> (sda && sda_s_oe_n)[*8])
        else $error("bus not idle after stop");
    chk_dev_data_stable: assert property (disable iff (!resetn_i || !ext_resetn)
        scl && $past(scl) |-> $stable(sda_s_oe_n))
        else $error("device data changed while clock high");
    chk_ack_pulls_low: assert property (s_ack_edge |-> !sda_s_oe_n && !sda)
        else $error("no acknowledge on ninth pulse");
    chk_ack_held_slot: assert property (s_ack_edge |-> ##1 (!sda_s_oe_n)[*8])
        else $error("acknowledge not held in slot");
    chk_master_ack_free: assert property (s_ack_edge |-> sda_m_oe_n)
        else $error("master drives data in ack slot");
    chk_dev_quiet_bits: assert property ($rose(scl) && bit_q < 4'h8 |-> sda_s_oe_n)
        else $error("device drives data during data bits");
    chk_addr_msb_first: assert property ($rose(scl) && byte_q == 2'h0 && bit_q < 4'h8
        |-> sda == addr_w[3'h7 - bit_q[2:0]])
        else $error("address bit wrong or out of order");
    chk_ext_reset_free: assert property ($fell(ext_resetn) |-> ##[1:4] sda_s_oe_n)
        else $error("data line held during reset pin low");
endmodule : lbc_link_props

// ---- testbench/led_driver_i2c_brightness_ctrl_tb_top.sv ----
// Testbench joining bus master and LED driver across the two-wire link
`timescale 1ns/1ns
module led_driver_i2c_brightness_ctrl_tb_top;
    localparam int STEP = lbc_pkg::CLK_HZ / (lbc_pkg::PWM_FREQ_HZ * lbc_pkg::PWM_STEPS);
    localparam int LIMIT = 95000;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic cmd_valid_i = 1'b0;
    logic [7:0] cmd_reg_i = 8'h00;
    logic [7:0] cmd_data_i = 8'h00;
    logic dev_reset_req_i = 1'b0;
    logic cmd_ready_o, done_o, nack_o, main_sink_on_o, aux_sink_on_o, fifth_sense_en_o, bus_busy_o;
    lbc_pkg::lbc_level_t main_level_o, aux_level_o;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;

    lbc_if link();
    lbc_host u_lbc_host (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .link(link), .cmd_valid_i(cmd_valid_i),
        .cmd_reg_i(cmd_reg_i), .cmd_data_i(cmd_data_i), .dev_reset_req_i(dev_reset_req_i),
        .cmd_ready_o(cmd_ready_o), .done_o(done_o), .nack_o(nack_o));
    lbc_dev u_lbc_dev (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .link(link),
        .main_sink_on_o(main_sink_on_o), .main_level_o(main_level_o), .aux_sink_on_o(aux_sink_on_o),
        .aux_level_o(aux_level_o), .fifth_sense_en_o(fifth_sense_en_o), .bus_busy_o(bus_busy_o));
    lbc_link_props u_lbc_link_props (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .scl(link.scl),
        .sda_m_o(link.sda_m_o), .sda_m_oe_n(link.sda_m_oe_n), .sda_s_o(link.sda_s_o),
        .sda_s_oe_n(link.sda_s_oe_n), .ext_resetn(link.ext_resetn), .sda(link.sda));

    ////////////////////////////////////////////////////////////////
    // Clock and hang guard
    always #(lbc_pkg::CLK_NS / 2) clk_sys_i = ~clk_sys_i;

    always @(posedge clk_sys_i)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fails++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////
    // Verdict, comparisons and bus helpers
    task automatic give_verdict;
        if (fails == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    task automatic chk_bit(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_bit

    task automatic chk_lvl(input string name, input lbc_pkg::lbc_level_t exp, input lbc_pkg::lbc_level_t got);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %0d seen %0d", name, exp, got);
        end
    endtask : chk_lvl

    task automatic chk_cnt(input string name, input int exp, input int got);
        n_tests++;
        if (got != exp)
        begin
            fails++;
            $display("Error %s expected %0d seen %0d", name, exp, got);
        end
    endtask : chk_cnt

    task automatic wait_hi(ref logic s);
        int n;
        n = 0;
        while (s !== 1'b1 && n < 5000)
        begin
            @(negedge clk_sys_i);
            n++;
        end
    endtask : wait_hi

    // One full register write frame, with busy and acknowledge checks
    task automatic write_reg(input logic [7:0] r, input logic [7:0] d);
        wait_hi(cmd_ready_o);
        cmd_reg_i = r;
        cmd_data_i = d;
        cmd_valid_i = 1'b1;
        @(negedge clk_sys_i);
        cmd_valid_i = 1'b0;
        chk_bit("ready_low", 1'b0, cmd_ready_o);
        repeat (300) @(negedge clk_sys_i);
        chk_bit("bus_busy", 1'b1, bus_busy_o);
        wait_hi(done_o);
        chk_bit("done", 1'b1, done_o);
        chk_bit("nack", 1'b0, nack_o);
        repeat (8) @(negedge clk_sys_i);
        chk_bit("bus_free", 1'b0, bus_busy_o);
    endtask : write_reg

    function automatic int exp_duty(input logic [4:0] c);
        if (c < 5'h10)
            return c + 1;
        if (c < 5'h17)
            return c - 6;
        if (c < 5'h1d)
            return c - 12;
        return (c == 5'h1d) ? 13 : (c == 5'h1e) ? 15 : 16;
    endfunction : exp_duty

    function automatic lbc_pkg::lbc_level_t exp_lvl(input logic [4:0] c);
        return (c < 5'h10) ? lbc_pkg::LBC_LVL_20 : (c < 5'h17) ? lbc_pkg::LBC_LVL_40 :
            (c < 5'h1d) ? lbc_pkg::LBC_LVL_70 : lbc_pkg::LBC_LVL_100;
    endfunction : exp_lvl

    ////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_power_on;
        repeat (4) @(negedge clk_sys_i);
        chk_lvl("aux_level", lbc_pkg::LBC_LVL_20, aux_level_o);
        chk_lvl("main_level", lbc_pkg::LBC_LVL_20, main_level_o);
        chk_bit("sense_en", 1'b1, fifth_sense_en_o);
        chk_bit("aux_on", 1'b0, aux_sink_on_o);
        chk_bit("main_on", 1'b0, main_sink_on_o);
    endtask : t_power_on

    // Boundary codes of the main table, unused top bits set
    task automatic t_main_map;
        logic [4:0] codes [8] = '{5'h00, 5'h0f, 5'h10, 5'h16, 5'h17, 5'h1c, 5'h1d, 5'h1e};
        int n;
        write_reg(lbc_pkg::REG_GENERAL_ENABLE, 8'h01);
        chk_bit("sense_off", 1'b0, fifth_sense_en_o);
        foreach (codes[i])
        begin
            write_reg(lbc_pkg::REG_MAIN_BANK_BRIGHTNESS, {3'h7, codes[i]});
            chk_lvl("main_level", exp_lvl(codes[i]), main_level_o);
            n = 0;
            repeat (lbc_pkg::PWM_STEPS * STEP)
            begin
                @(negedge clk_sys_i);
                n += (main_sink_on_o === 1'b1) ? 1 : 0;
            end
            chk_cnt("main_on_cycles", exp_duty(codes[i]) * STEP, n);
        end
    endtask : t_main_map

    task automatic t_aux;
        write_reg(lbc_pkg::REG_GENERAL_ENABLE, 8'h24);
        chk_bit("aux_on", 1'b1, aux_sink_on_o);
        chk_bit("sense_on", 1'b1, fifth_sense_en_o);
        for (int i = 0; i < 4; i++)
        begin
            write_reg(lbc_pkg::REG_AUX_SINK_BRIGHTNESS, {6'h3f, 2'(i)});
            chk_lvl("aux_level", lbc_pkg::lbc_level_t'(2'(i)), aux_level_o);
            chk_bit("main_off", 1'b0, main_sink_on_o);
        end
    endtask : t_aux

    task automatic t_unmapped;
        write_reg(8'h11, 8'h00);
        chk_lvl("aux_kept", lbc_pkg::LBC_LVL_100, aux_level_o);
        chk_bit("aux_on_kept", 1'b1, aux_sink_on_o);
        chk_bit("sense_kept", 1'b1, fifth_sense_en_o);
    endtask : t_unmapped

    task automatic t_ext_reset;
        dev_reset_req_i = 1'b1;
        repeat (8) @(negedge clk_sys_i);
        chk_lvl("aux_level", lbc_pkg::LBC_LVL_20, aux_level_o);
        chk_bit("aux_on", 1'b0, aux_sink_on_o);
        chk_bit("main_on", 1'b0, main_sink_on_o);
        chk_bit("sense_en", 1'b0, fifth_sense_en_o);
        dev_reset_req_i = 1'b0;
        repeat (6) @(negedge clk_sys_i);
        chk_bit("sense_back", 1'b1, fifth_sense_en_o);
        chk_bit("aux_off", 1'b0, aux_sink_on_o);
    endtask : t_ext_reset

    // Main sequence
    initial
    begin
        repeat (3) @(negedge clk_sys_i);
        resetn_i = 1'b1;
        t_power_on();
        t_main_map();
        t_aux();
        t_unmapped();
        t_ext_reset();
        give_verdict();
    end
endmodule : led_driver_i2c_brightness_ctrl_tb_top
